// File: design/anpr_pkg.sv
package anpr_pkg;

  // Word indexes; printed offsets 0x5, 0x7, 0x11 are not multiples of four,
  // so each printed offset is an index and the address is four times it
  localparam logic [7:0] IDX_ADV = 8'h04;
  localparam logic [7:0] IDX_PBASE = 8'h05;
  localparam logic [7:0] IDX_EXP = 8'h06;
  localparam logic [7:0] IDX_LNP = 8'h07;
  localparam logic [7:0] IDX_PNP = 8'h08;
  localparam logic [7:0] IDX_DCTL = 8'h10;
  localparam logic [7:0] IDX_AFE1 = 8'h11;
  localparam logic [7:0] IDX_EVT = 8'h20;

  // Field positions
  localparam int ADV_100FD = 8;
  localparam int ADV_100HD = 7;
  localparam int ADV_10FD = 6;
  localparam int ADV_10HD = 5;
  localparam int NP_MORE = 15;
  localparam int NP_ACK = 14;
  localparam int NP_MSG = 13;
  localparam int NP_ACK2 = 12;
  localparam int NP_TOG = 11;
  localparam int EXP_PDF = 4;
  localparam int EXP_PNPA = 3;
  localparam int EXP_LNPA = 2;
  localparam int EXP_PRX = 1;
  localparam int EXP_PANA = 0;
  localparam int DCTL_PLLOFF = 4;

  // Reset values
  localparam logic [4:0] SEL_RST = 5'h01;
  localparam logic [4:0] SEL_8023 = 5'h01;
  localparam logic [10:0] LMSG_RST = 11'h001;
  localparam logic [15:0] LNP_RST = 16'h2001;
  localparam logic [15:0] DCTL_RST = 16'h0000;
  localparam logic [15:0] AFE1_RST = 16'h0000;

  // Strap sampling state
  typedef enum logic [1:0] {
    ANPR_ST_IDLE = 2'b01,
    ANPR_ST_DONE = 2'b10
  } anpr_strap_t;

endpackage

// File: design/anpr_regs.sv
//////////////////////////////////////////////////////////////////////////////
// How it works
// - 100M full/half advertise bits writable, reset from sampled speed strap.
// - 10M full/half advertise bits writable, reset to one.
// - Local selector writable, resets to 00001 (802.3).
// - Partner base page read-only, zero reset; next-page, fault copied, ack reads one.
// - Partner pause field read-only, reset 00, four pause encodings.
// - Partner technology bits read-only, reset zero, show partner abilities.
// - Partner selector reads zero until negotiation completes, then 00001.
// - Parallel detection fault bit latches high, resets zero.
// - Partner next-page-able bit read-only, resets zero.
// - Local next-page-able bit reads one from reset.
// - Page received bit latches high, resets zero.
// - Partner negotiation-able bit read-only, resets zero.
// - Local more-pages bit resets zero; message-page bit resets one.
// - Local comply acknowledge bit writable, resets zero.
// - Local toggle read-only, reset zero, shows last sent toggle.
// - Local eleven-bit message field writable, resets to one.
// - Partner next page read-only, zero reset; more, type copied, ack reads one.
// - Partner comply acknowledge read-only, resets zero.
// - Partner toggle reads inverse of previously sent toggle.
// - Partner eleven-bit message field read-only, resets zero.
// - PLL-off control bit writable, resets zero, drives power-down PLL.
module anpr_regs
  import anpr_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Strap pin
  input  wire logic        speed_strap,
  // Negotiation engine status
  input  wire logic        partner_word_valid,
  input  wire logic [15:0] partner_word,
  input  wire logic        partner_is_next_page,
  input  wire logic        auto_negotiation_done,
  input  wire logic        parallel_detect_fault,
  input  wire logic        partner_auto_negotiation_able,
  input  wire logic        sent_toggle_valid,
  input  wire logic        sent_toggle,
  // Control outputs
  output logic      [15:0] local_advertisement,
  output logic      [15:0] local_next_page,
  output logic             energy_detect_power_down_pll_off
);

  //////////////////////////////////////////////////////////////////////////
  // Strap synchroniser and sampling at first clocks after reset
  logic        strap_s1_r;
  logic        strap_s2_r;
  anpr_strap_t strap_st_r;
  anpr_strap_t strap_st_nxt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
    end else begin
      strap_s1_r <= speed_strap;
      strap_s2_r <= strap_s1_r;
    end
  end

  // Strap sampled once the synchroniser has filled
  // Two stages of delay: the second synchroniser flop only holds the pin
  // after the second edge, so taking it earlier would load the reset zero
  logic strap_fill_r;
  logic strap_wait_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_fill_r <= 1'b0;
      strap_wait_r <= 1'b0;
    end else begin
      strap_fill_r <= 1'b1;
      strap_wait_r <= strap_fill_r;
    end
  end

  always_comb begin
    case (strap_st_r)
      ANPR_ST_IDLE: strap_st_nxt = strap_wait_r ? ANPR_ST_DONE : ANPR_ST_IDLE;
      ANPR_ST_DONE: strap_st_nxt = ANPR_ST_DONE;
      default:      strap_st_nxt = ANPR_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_st_r <= ANPR_ST_IDLE;
    end else begin
      strap_st_r <= strap_st_nxt;
    end
  end

  wire strap_take = (strap_st_r == ANPR_ST_IDLE) && strap_wait_r;

  //////////////////////////////////////////////////////////////////////////
  // APB decode
  wire        apb_acc = psel && penable;
  wire [9:0]  word_idx = paddr[11:2];
  wire        hit_adv = (word_idx == {2'b00, IDX_ADV});
  wire        hit_pbase = (word_idx == {2'b00, IDX_PBASE});
  wire        hit_exp = (word_idx == {2'b00, IDX_EXP});
  wire        hit_lnp = (word_idx == {2'b00, IDX_LNP});
  wire        hit_pnp = (word_idx == {2'b00, IDX_PNP});
  wire        hit_dctl = (word_idx == {2'b00, IDX_DCTL});
  wire        hit_afe1 = (word_idx == {2'b00, IDX_AFE1});
  wire        hit_any = hit_adv | hit_pbase | hit_exp | hit_lnp | hit_pnp |
                        hit_dctl | hit_afe1;
  wire        wr_en = apb_acc && pwrite;
  wire        rd_en = apb_acc && !pwrite;
  wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  //////////////////////////////////////////////////////////////////////////
  // Local advertisement: only speed, duplex and selector bits live here
  localparam logic [15:0] ADV_WMASK = 16'h01FF;
  logic [15:0] adv_r;
  logic [15:0] adv_nxt;

  always_comb begin
    adv_nxt = adv_r;
    if (strap_take) begin
      adv_nxt[ADV_100FD] = strap_s2_r;
      adv_nxt[ADV_100HD] = strap_s2_r;
    end
    if (wr_en && hit_adv) begin
      adv_nxt = (adv_r & ~(wmask & ADV_WMASK)) |
                (pwdata[15:0] & wmask & ADV_WMASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_r <= {7'h00, 2'b00, 1'b1, 1'b1, SEL_RST};
    end else begin
      adv_r <= adv_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Partner base page and partner next page capture
  logic [15:0] pbase_r;
  logic [15:0] pnp_r;
  wire         take_base = partner_word_valid && !partner_is_next_page;
  wire         take_np = partner_word_valid && partner_is_next_page;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pbase_r <= 16'h0000;
      pnp_r <= 16'h0000;
    end else begin
      if (take_base) begin
        pbase_r <= {partner_word[15], 1'b1, partner_word[13], 1'b0,
                    partner_word[11:5], 5'h00};
      end
      if (take_np) begin
        pnp_r <= {partner_word[15], 1'b1, partner_word[13:12],
                  pnp_r[NP_TOG], partner_word[10:0]};
      end
      if (sent_toggle_valid) begin
        pnp_r[NP_TOG] <= !sent_toggle;
      end
    end
  end

  // Selector visible only after negotiation completes
  wire [4:0]  psel_fld = auto_negotiation_done ? SEL_8023 : 5'h00;
  wire [15:0] pbase_rd = {pbase_r[15:5], psel_fld};

  //////////////////////////////////////////////////////////////////////////
  // Expansion: fault and page-received bits latch high, cleared by a read, set wins
  logic pdf_r;
  logic prx_r;
  logic pnpa_r;
  wire  exp_rd = rd_en && hit_exp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdf_r <= 1'b0;
      prx_r <= 1'b0;
      pnpa_r <= 1'b0;
    end else begin
      pdf_r <= parallel_detect_fault | (pdf_r & !exp_rd);
      prx_r <= partner_word_valid | (prx_r & !exp_rd);
      if (take_base) begin
        pnpa_r <= partner_word[15];
      end
    end
  end

  wire [15:0] exp_rd_val = {11'h000, pdf_r, pnpa_r, 1'b1, prx_r,
                            partner_auto_negotiation_able};

  //////////////////////////////////////////////////////////////////////////
  // Local next page: toggle is hardware owned, reserved bit 14 reads zero
  localparam logic [15:0] LNP_WMASK = 16'hB7FF;
  logic [15:0] lnp_r;
  logic [15:0] lnp_nxt;

  always_comb begin
    lnp_nxt = lnp_r;
    if (wr_en && hit_lnp) begin
      lnp_nxt = (lnp_r & ~(wmask & LNP_WMASK)) |
                (pwdata[15:0] & wmask & LNP_WMASK);
    end
    if (sent_toggle_valid) begin
      lnp_nxt[NP_TOG] = sent_toggle;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnp_r <= LNP_RST;
    end else begin
      lnp_r <= lnp_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Digital control and front-end control, fully writable
  logic [15:0] dctl_r;
  logic [15:0] afe1_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dctl_r <= DCTL_RST;
      afe1_r <= AFE1_RST;
    end else begin
      if (wr_en && hit_dctl) begin
        dctl_r <= (dctl_r & ~wmask) | (pwdata[15:0] & wmask);
      end
      if (wr_en && hit_afe1) begin
        afe1_r <= (afe1_r & ~wmask) | (pwdata[15:0] & wmask);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [15:0] rd_mux =
    hit_adv   ? adv_r :
    hit_pbase ? pbase_rd :
    hit_exp   ? exp_rd_val :
    hit_lnp   ? lnp_r :
    hit_pnp   ? pnp_r :
    hit_dctl  ? dctl_r :
    hit_afe1  ? afe1_r : 16'h0000;

  // Read data registered on the setup cycle so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rd_mux};
    end
  end

  // Zero-wait answers; unmapped addresses flag an error
  assign pready = 1'b1;
  assign pslverr = apb_acc && !hit_any;

  //////////////////////////////////////////////////////////////////////////
  // Outputs to the negotiation engine and power logic
  assign local_advertisement = adv_r;
  assign local_next_page = lnp_r;
  assign energy_detect_power_down_pll_off = dctl_r[DCTL_PLLOFF];

endmodule

// File: testbench/anpr_regs_props.sv
module anpr_regs_props
  import anpr_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Toggle and control outputs
  input wire logic        sent_toggle_valid,
  input wire logic        sent_toggle,
  input wire logic [15:0] local_advertisement,
  input wire logic [15:0] local_next_page,
  input wire logic        energy_detect_power_down_pll_off
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Decoded write strobes per register; lane 1 matters for bits 15:8
  wire       acc     = psel & penable;
  wire       wr_lo   = acc & pwrite & pstrb[0];
  wire       wr_both = wr_lo & pstrb[1];
  wire [9:0] ix      = paddr[11:2];
  wire       w_adv   = wr_both && ix == 10'(IDX_ADV);
  wire       w_lnp   = wr_both && ix == 10'(IDX_LNP);
  wire       w_dctl  = wr_lo && ix == 10'(IDX_DCTL);
  wire       mapped  = ix inside {4, 5, 6, 7, 8, 16, 17};

  a_no_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("error response on a mapped register");
  a_adv_reset: assert property ($rose(presetn) |->
    local_advertisement[6:0] == 7'h61) else $error("bad advert reset");
  a_lnp_reset: assert property ($rose(presetn) |->
    local_next_page == LNP_RST) else $error("bad next page reset");
  a_adv_write: assert property (w_adv |=>
    local_advertisement[8:0] == $past(pwdata[8:0]))
    else $error("advert write lost");
  a_lnp_write: assert property (w_lnp |=>
    {local_next_page[15], local_next_page[13:12], local_next_page[10:0]} ==
    $past({pwdata[15], pwdata[13:12], pwdata[10:0]}))
    else $error("next page write lost");
  a_lnp_rsvd: assert property (local_next_page[14] == 1'b0)
    else $error("reserved next page bit set");
  a_tog_track: assert property (sent_toggle_valid |=>
    local_next_page[NP_TOG] == $past(sent_toggle))
    else $error("local toggle wrong");
  a_pll_write: assert property (w_dctl |=>
    energy_detect_power_down_pll_off == $past(pwdata[DCTL_PLLOFF]))
    else $error("pll off bit not written");
  a_pll_hold: assert property (!w_dctl |=>
    $stable(energy_detect_power_down_pll_off))
    else $error("pll off bit moved");
  a_rdata_high: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read data set");
endmodule

bind anpr_regs anpr_regs_props u_props (.*);

// File: testbench/anpr_link_model.sv
module anpr_link_model (
  // Clock
  input wire logic        pclk,
  // Received word towards the register set
  output logic            partner_word_valid,
  output logic     [15:0] partner_word,
  output logic            partner_is_next_page
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    partner_word_valid = 1'b0;
    partner_word = 16'h0000;
    partner_is_next_page = 1'b0;
  end

  // One received word; the word lines go stale-inverted afterwards
  task automatic send(input logic [15:0] w, input logic np);
    @(posedge pclk);
    partner_word_valid <= 1'b1;
    partner_word <= w;
    partner_is_next_page <= np;
    @(posedge pclk);
    partner_word_valid <= 1'b0;
    partner_word <= ~w;
  endtask
endmodule

// File: testbench/anpr_regs_tb.sv
module anpr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, speed_strap = 1, sent_toggle_valid = 0;
  logic        sent_toggle = 0, auto_negotiation_done = 0;
  logic        parallel_detect_fault = 0, partner_auto_negotiation_able = 0;
  logic        partner_word_valid, partner_is_next_page;
  logic        energy_detect_power_down_pll_off;
  logic [15:0] partner_word, local_advertisement, local_next_page, w;
  int          err_count = 0, comparisons = 0;
  logic [11:0] ra [7] = '{12'h010, 12'h014, 12'h018, 12'h01C, 12'h020,
                          12'h040, 12'h044};
  logic [31:0] rv [7] = '{32'h01E1, 0, 32'h0004, 32'h2001, 0, 0, 0};
  logic [31:0] fv [7] = '{32'h01FF, 0, 32'h0004, 32'hB7FF, 0, 32'hFFFF,
                          32'hFFFF};

  anpr_regs dut (.*);
  anpr_link_model lp (.*);

  // Clock
  always #25 pclk = ~pclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic xfer(input logic wt, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wt;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask

  task automatic tog(input logic v);
    sent_toggle_valid <= 1'b1;
    sent_toggle <= v;
    @(posedge pclk);
    sent_toggle_valid <= 1'b0;
  endtask

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    final_report();
  end

  initial begin
    logic [31:0] q;
    logic        e;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 7; i++) rc(ra[i], rv[i]);
    xfer(1'b0, 12'h00C, 32'h0, q, e);
    chk({q[31:1], e}, 32'h1);
    for (int i = 0; i < 7; i++) begin
      wr(ra[i], 32'hFFFF);
      rc(ra[i], fv[i]);
    end
    chk(energy_detect_power_down_pll_off, 1);
    for (int i = 0; i < 7; i++) begin
      wr(ra[i], 32'h0);
      rc(ra[i], (i == 2) ? 32'h4 : 32'h0);
    end
    for (int p = 0; p < 4; p++) begin
      w = {4'b1010, 2'(p), 10'b1010100011};
      lp.send(w, 1'b0);
      rc(12'h014, {16'h0, (w & 16'hAFE0) | 16'h4000});
    end
    auto_negotiation_done <= 1'b1;
    rc(12'h014, {16'h0, (w & 16'hAFE0) | 16'h4001});
    partner_auto_negotiation_able <= 1'b1;
    rc(12'h018, 32'h000F);
    rc(12'h018, 32'h000D);
    parallel_detect_fault <= 1'b1;
    @(posedge pclk);
    parallel_detect_fault <= 1'b0;
    rc(12'h018, 32'h001D);
    rc(12'h018, 32'h000D);
    tog(1'b1);
    lp.send(16'hF555, 1'b1);
    rc(12'h020, 32'hF555);
    chk(local_next_page[11], 1);
    tog(1'b0);
    lp.send(16'hF555, 1'b1);
    rc(12'h020, 32'hFD55);
    chk(local_next_page[11], 0);
    speed_strap <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rc(12'h010, 32'h0061);
    final_report();
  end
endmodule
